/* hdl/csel_axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes one write and one read in flight at most; mclk_in domain only.
`timescale 1ns/1ps
`default_nettype none
module csel_axil_slave (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    csel_reg_if.slave        rif
);
    logic        aw_held_reg;
    logic        w_held_reg;
    logic        wr_stb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        ar_held_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [7:0]  araddr_reg;
    logic [31:0] rdata_reg;
    wire         write_busy;

    // Address and data are refused until the previous response has gone
    assign write_busy        = wr_stb_reg | bvalid_reg;
    assign s_axi_awready_out = ~aw_held_reg & ~write_busy;
    assign s_axi_wready_out  = ~w_held_reg & ~write_busy;
    assign s_axi_arready_out = ~ar_held_reg & ~rvalid_reg;
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    assign s_axi_rvalid_out  = rvalid_reg;
    assign s_axi_rresp_out   = rresp_reg;
    assign s_axi_rdata_out   = rdata_reg;

    assign rif.wr_stb   = wr_stb_reg;
    assign rif.wr_addr  = awaddr_reg;
    assign rif.wr_data  = wdata_reg;
    assign rif.wr_strb  = wstrb_reg;
    assign rif.bus_done = bvalid_reg & s_axi_bready_in;
    assign rif.rd_addr  = araddr_reg;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            wr_stb_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= csel_pkg::RESP_OKAY;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else begin
            wr_stb_reg <= aw_held_reg & w_held_reg;
            if (s_axi_awvalid_in & s_axi_awready_out) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in & s_axi_wready_out) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_in;
                wstrb_reg  <= s_axi_wstrb_in;
            end
            if (aw_held_reg & w_held_reg) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end
            if (wr_stb_reg) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= rif.wr_hit ? csel_pkg::RESP_OKAY : csel_pkg::RESP_DECERR;
            end else if (bvalid_reg & s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ar_held_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= csel_pkg::RESP_OKAY;
            araddr_reg  <= 8'h00;
            rdata_reg   <= 32'h0000_0000;
        end else begin
            if (s_axi_arvalid_in & s_axi_arready_out) begin
                ar_held_reg <= 1'b1;
                araddr_reg  <= s_axi_araddr_in;
            end
            if (ar_held_reg) begin
                ar_held_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rif.rd_data;
                rresp_reg   <= rif.rd_hit ? csel_pkg::RESP_OKAY : csel_pkg::RESP_DECERR;
            end else if (rvalid_reg & s_axi_rready_in) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
endmodule : csel_axil_slave
`default_nettype wire

/* hdl/csel_clock_source_select.sv */
// Clock source select: main PLL clock with dividers, or subclock, for core,
// peripheral and external bus clocks. Assumes mclk_in stands for twice the PLL
// rate; subclock and oscillator-ready arrive asynchronously on pins.
`timescale 1ns/1ps
`default_nettype none
module csel_clock_source_select (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        subclk_in,
    input  wire logic        main_osc_ready_in,
    input  wire logic        subclock_osc_halt_in,
    input  wire logic        standby_in,
    input  wire logic        standby_exit_in,
    output logic             core_clk_out,
    output logic             periph_clk_out,
    output logic             bus_clk_out,
    output logic             main_osc_en_out,
    output logic             pll_en_out,
    output logic             on_subclock_out
);
    csel_reg_if rif ();

    csel_axil_slave u_slave (
        .mclk_in           (mclk_in),
        .srst_in           (srst_in),
        .s_axi_awaddr_in   (s_axi_awaddr_in),
        .s_axi_awvalid_in  (s_axi_awvalid_in),
        .s_axi_awready_out (s_axi_awready_out),
        .s_axi_wdata_in    (s_axi_wdata_in),
        .s_axi_wstrb_in    (s_axi_wstrb_in),
        .s_axi_wvalid_in   (s_axi_wvalid_in),
        .s_axi_wready_out  (s_axi_wready_out),
        .s_axi_bresp_out   (s_axi_bresp_out),
        .s_axi_bvalid_out  (s_axi_bvalid_out),
        .s_axi_bready_in   (s_axi_bready_in),
        .s_axi_araddr_in   (s_axi_araddr_in),
        .s_axi_arvalid_in  (s_axi_arvalid_in),
        .s_axi_arready_out (s_axi_arready_out),
        .s_axi_rdata_out   (s_axi_rdata_out),
        .s_axi_rresp_out   (s_axi_rresp_out),
        .s_axi_rvalid_out  (s_axi_rvalid_out),
        .s_axi_rready_in   (s_axi_rready_in),
        .rif               (rif.slave)
    );

    // Pin synchronisers: bit 0 subclock, bit 1 oscillator ready
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] sync3_reg;
    logic [1:0] filt_reg;
    logic       sub_prev_reg;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sync1_reg    <= 2'h0;
            sync2_reg    <= 2'h0;
            sync3_reg    <= 2'h0;
            filt_reg     <= 2'h0;
            sub_prev_reg <= 1'b0;
        end else begin
            sync1_reg    <= {main_osc_ready_in, subclk_in};
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            filt_reg     <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
            sub_prev_reg <= filt_reg[0];
        end
    end

    wire sub_level = filt_reg[0];
    wire main_ready = filt_reg[1];
    wire sub_fall = sub_prev_reg & ~sub_level;

    // Register state
    logic [2:0]          csc_reg;
    logic [2:0]          div_core_reg;
    logic [2:0]          div_per_reg;
    logic [2:0]          div_bus_reg;
    logic                div_wr_seen_reg;
    logic                pend_reg;
    logic [1:0]          act_core_reg;
    logic [1:0]          act_per_reg;
    logic [1:0]          act_bus_reg;
    logic [3:0]          cnt_reg;
    csel_pkg::csel_src_t state_reg;
    csel_pkg::csel_src_t state_next;
    logic [2:0]          clk_reg;

    wire sub_sel  = csc_reg[csel_pkg::CSC_SUB_BIT];
    wire wake_sel = csc_reg[csel_pkg::CSC_WAKE_BIT];
    wire stop_sel = csc_reg[csel_pkg::CSC_STOP_BIT];

    // Write decode
    wire wr_csc = rif.wr_stb & (rif.wr_addr == csel_pkg::OFF_CSC) & rif.wr_strb[0];
    wire wr_div = rif.wr_stb & (rif.wr_addr == csel_pkg::OFF_DIV);
    wire [2:0] csc_wdata = rif.wr_data[2:0];  // Upper bits dropped
    // A stopped subclock cannot be selected
    wire sub_wr_allowed = ~(csc_wdata[csel_pkg::CSC_SUB_BIT] & subclock_osc_halt_in);
    wire sub_wr_value = sub_wr_allowed ? csc_wdata[csel_pkg::CSC_SUB_BIT] : sub_sel;
    // Wakeup select 0 falls back to main clock
    wire exit_clear = standby_exit_in & ~wake_sel;

    assign rif.wr_hit = (rif.wr_addr == csel_pkg::OFF_CSC) | (rif.wr_addr == csel_pkg::OFF_DIV)
                      | (rif.wr_addr == csel_pkg::OFF_STAT);

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            csc_reg <= csel_pkg::CSC_RESET;
        end else if (exit_clear) begin
            csc_reg[csel_pkg::CSC_SUB_BIT] <= 1'b0;
            if (wr_csc) begin
                csc_reg[2:1] <= csc_wdata[2:1];
            end
        end else if (wr_csc) begin
            csc_reg <= {csc_wdata[2:1], sub_wr_value};
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            div_core_reg <= csel_pkg::DIV_CORE_RESET;
            div_per_reg  <= csel_pkg::DIV_PER_RESET;
            div_bus_reg  <= csel_pkg::DIV_BUS_RESET;
        end else if (wr_div) begin
            if (rif.wr_strb[0]) begin
                div_per_reg <= rif.wr_data[csel_pkg::DIV_PER_LSB +: 3];
                div_bus_reg <= rif.wr_data[csel_pkg::DIV_BUS_LSB +: 3];
            end
            if (rif.wr_strb[1]) begin
                div_core_reg <= rif.wr_data[csel_pkg::DIV_CORE_LSB +: 3];
            end
        end
    end

    // Codes above 1/8 are clamped; peripheral and bus follow core if faster
    wire [1:0] core_code = div_core_reg[2] ? csel_pkg::RATIO_MAX : div_core_reg[1:0];
    wire [1:0] per_raw   = div_per_reg[2] ? csel_pkg::RATIO_MAX : div_per_reg[1:0];
    wire [1:0] bus_raw   = div_bus_reg[2] ? csel_pkg::RATIO_MAX : div_bus_reg[1:0];
    wire [1:0] per_code  = (per_raw < core_code) ? core_code : per_raw;
    wire [1:0] bus_code  = (bus_raw < core_code) ? core_code : bus_raw;

    // Apply point is one input-clock period apart, so the wait is bounded
    wire apply_now = pend_reg & (cnt_reg[2:0] == csel_pkg::APPLY_PHASE);

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            div_wr_seen_reg <= 1'b0;
            pend_reg        <= 1'b0;
            act_core_reg    <= csel_pkg::DIV_CORE_RESET[1:0];
            act_per_reg     <= csel_pkg::DIV_PER_RESET[1:0];
            act_bus_reg     <= csel_pkg::DIV_BUS_RESET[1:0];
        end else begin
            if (wr_div) begin
                div_wr_seen_reg <= 1'b1;
            end else if (rif.bus_done) begin
                div_wr_seen_reg <= 1'b0;
            end
            // Set wins over the clear of the same cycle
            if (rif.bus_done & div_wr_seen_reg) begin
                pend_reg <= 1'b1;
            end else if (apply_now) begin
                pend_reg <= 1'b0;
            end
            if (apply_now) begin
                act_core_reg <= core_code;
                act_per_reg  <= per_code;
                act_bus_reg  <= bus_code;
            end
        end
    end

    // Oscillator and PLL enables
    wire on_sub_side = (state_reg == csel_pkg::SRC_SUB) | (state_reg == csel_pkg::SRC_GATE_TO_SUB);
    wire osc_en = ~standby_in & ~(stop_sel & sub_sel & on_sub_side);
    assign main_osc_en_out = osc_en;
    assign pll_en_out      = osc_en;

    // Counter stands for the PLL and its divider chain
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cnt_reg <= 4'h0;
        end else if (osc_en & main_ready) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    // Source switch: outputs held low between old and new source
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            csel_pkg::SRC_MAIN: begin
                if (sub_sel & (cnt_reg == csel_pkg::CNT_WRAP)) begin
                    state_next = csel_pkg::SRC_GATE_TO_SUB;
                end
            end
            csel_pkg::SRC_GATE_TO_SUB: begin
                if (~sub_sel) begin
                    state_next = csel_pkg::SRC_GATE_TO_MAIN;
                end else if (sub_fall) begin
                    state_next = csel_pkg::SRC_SUB;
                end
            end
            csel_pkg::SRC_SUB: begin
                // Wakeup select 1 keeps the subclock since the bit stays set
                if (~sub_sel & sub_fall) begin
                    state_next = csel_pkg::SRC_GATE_TO_MAIN;
                end
            end
            csel_pkg::SRC_GATE_TO_MAIN: begin
                if (main_ready & osc_en & (cnt_reg == csel_pkg::CNT_WRAP)) begin
                    state_next = csel_pkg::SRC_MAIN;
                end
            end
            default: begin
                state_next = csel_pkg::SRC_MAIN;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_reg <= csel_pkg::SRC_MAIN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Per-clock level: 0 core, 1 peripheral, 2 bus
    wire [1:0] act_code [3];
    wire [2:0] clk_level;
    assign act_code[0] = act_core_reg;
    assign act_code[1] = act_per_reg;
    assign act_code[2] = act_bus_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_clk
            assign clk_level[gi] = (state_reg == csel_pkg::SRC_MAIN) ? cnt_reg[act_code[gi]] :
                                   (state_reg == csel_pkg::SRC_SUB) ? sub_level : 1'b0;
        end
    endgenerate

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            clk_reg <= 3'h0;
        end else begin
            clk_reg <= clk_level;
        end
    end

    assign core_clk_out    = clk_reg[0];
    assign periph_clk_out  = clk_reg[1];
    assign bus_clk_out     = clk_reg[2];
    assign on_subclock_out = (state_reg == csel_pkg::SRC_SUB);

    // Read mux
    wire [31:0] csc_rd  = {29'h0, csc_reg};
    wire [31:0] div_rd  = {21'h0, div_core_reg, 1'b0, div_per_reg, 1'b0, div_bus_reg};
    wire [31:0] stat_rd = {28'h000_0000, pend_reg, osc_en,
                           (state_reg == csel_pkg::SRC_GATE_TO_SUB)
                           | (state_reg == csel_pkg::SRC_GATE_TO_MAIN),
                           (state_reg == csel_pkg::SRC_SUB)};

    assign rif.rd_hit  = (rif.rd_addr == csel_pkg::OFF_CSC) | (rif.rd_addr == csel_pkg::OFF_DIV)
                       | (rif.rd_addr == csel_pkg::OFF_STAT);
    assign rif.rd_data = (rif.rd_addr == csel_pkg::OFF_CSC)  ? csc_rd :
                         (rif.rd_addr == csel_pkg::OFF_DIV)  ? div_rd :
                         (rif.rd_addr == csel_pkg::OFF_STAT) ? stat_rd : 32'h0000_0000;
endmodule : csel_clock_source_select
`default_nettype wire

/* hdl/csel_pkg.sv */
// Constants, register map and state type of the clock source select block.
// Assumes a single system clock; no other package is needed.
package csel_pkg;
    localparam int unsigned ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_CSC  = 8'h00;
    localparam logic [7:0] OFF_DIV  = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;

    // Clock source control fields
    localparam int unsigned CSC_SUB_BIT  = 0;
    localparam int unsigned CSC_WAKE_BIT = 1;
    localparam int unsigned CSC_STOP_BIT = 2;
    localparam int unsigned CSC_W        = 3;
    localparam logic [2:0]  CSC_RESET    = 3'h0;

    // Divider control fields, three bits each
    localparam int unsigned DIV_BUS_LSB    = 0;
    localparam int unsigned DIV_PER_LSB    = 4;
    localparam int unsigned DIV_CORE_LSB   = 8;
    localparam logic [2:0]  DIV_BUS_RESET  = 3'h0;
    localparam logic [2:0]  DIV_PER_RESET  = 3'h0;
    localparam logic [2:0]  DIV_CORE_RESET = 3'h0;

    // Status fields
    localparam int unsigned STAT_SUB_BIT     = 0;
    localparam int unsigned STAT_SWITCH_BIT  = 1;
    localparam int unsigned STAT_OSC_BIT     = 2;
    localparam int unsigned STAT_PEND_BIT    = 3;

    // One system cycle is half a PLL period; the input clock is PLL_MULT PLL periods
    localparam int unsigned PLL_MULT   = 4;
    localparam int unsigned CNT_W      = 4;
    localparam int unsigned IN_CLK_CYC = 2 * PLL_MULT;
    localparam logic [3:0]  CNT_WRAP   = 4'hF;
    localparam logic [2:0]  APPLY_PHASE = 3'(IN_CLK_CYC - 1);
    localparam logic [1:0]  RATIO_MAX  = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        SRC_MAIN,
        SRC_GATE_TO_SUB,
        SRC_SUB,
        SRC_GATE_TO_MAIN
    } csel_src_t;
endpackage : csel_pkg

/* hdl/csel_reg_if.sv */
// Register access carrier between the bus slave and the clock core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface csel_reg_if;
    logic        wr_stb;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_hit;
    logic        bus_done;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_hit;

    modport slave (output wr_stb, wr_addr, wr_data, wr_strb, bus_done, rd_addr,
                   input wr_hit, rd_data, rd_hit);
    modport core  (input wr_stb, wr_addr, wr_data, wr_strb, bus_done, rd_addr,
                   output wr_hit, rd_data, rd_hit);
endinterface : csel_reg_if
`default_nettype wire

/* testbench/csel_clock_source_select_tb.sv */
// Self-checking bench: register sequences over AXI4-Lite.
// Assumes this bench drives every pin; subclock is a slow stand-in.
`timescale 1ns/1ps
`default_nettype none
module csel_clock_source_select_tb;
    logic        mclk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic        sclk = 1'b0, halt = 1'b0, sby = 1'b0, sbx = 1'b0;
    logic [7:0]  awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0]  bresp, rresp;
    logic        awr, wr, bv, arr, rv, oen, pen, onsub;
    logic [2:0]  clks;
    int          err_count = 0, compares = 0, cyc = 0;

    always #50 mclk_in = ~mclk_in;
    always begin
        repeat (10) @(posedge mclk_in);
        sclk <= ~sclk;
    end
    csel_clock_source_select csel_clock_source_select_inst (
        .mclk_in(mclk_in), .srst_in(srst_in), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
        .subclk_in(sclk), .main_osc_ready_in(1'b1), .subclock_osc_halt_in(halt),
        .standby_in(sby), .standby_exit_in(sbx), .core_clk_out(clks[2]),
        .periph_clk_out(clks[1]), .bus_clk_out(clks[0]), .main_osc_en_out(oen),
        .pll_en_out(pen), .on_subclock_out(onsub));

    task automatic close_out;
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Ready is sampled at the negedge; inputs only move at posedge
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ha, hw, hb;
        logic [1:0] rb;
        @(posedge mclk_in);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(negedge mclk_in);
            ha = awv && awr;
            hw = wv && wr;
            hb = br && bv;
            rb = bresp;
            @(posedge mclk_in);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
            if (hb) br <= 1'b0;
        end while (!hb);
        chk("bresp", {30'h0, er}, {30'h0, rb});
    endtask : axw
    task automatic rdk(input string n, input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        logic ha, hr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk_in);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(negedge mclk_in);
            ha = arv && arr;
            hr = rr && rv;
            d = rd;
            r = rresp;
            @(posedge mclk_in);
            if (ha) arv <= 1'b0;
            if (hr) rr <= 1'b0;
        end while (!hr);
        chk(n, e, d);
        chk(n, {30'h0, er}, {30'h0, r});
    endtask : rdk
    // Source control write, then the two reads software owes before relying on it
    task automatic csw(input logic [31:0] d, input logic [31:0] e);
        axw(8'h00, d, 2'h0);
        rdk("csc_dummy1", 8'h00, e, 2'h0);
        rdk("csc_dummy2", 8'h00, e, 2'h0);
    endtask : csw
    // Period in mclk cycles, rising edge to rising edge
    task automatic per(input int i, input logic [31:0] e, input string n);
        logic [31:0] p;
        p = 32'h0;
        while (clks[i] !== 1'b0) @(negedge mclk_in);
        while (clks[i] !== 1'b1) @(negedge mclk_in);
        while (clks[i] === 1'b1) begin @(negedge mclk_in); p++; end
        while (clks[i] === 1'b0) begin @(negedge mclk_in); p++; end
        chk(n, e, p);
    endtask : per
    task automatic waitsub(input logic v);
        for (int k = 0; k < 400 && onsub !== v; k++) @(negedge mclk_in);
    endtask : waitsub
    task automatic wake;
        @(posedge mclk_in);
        sby <= 1'b0;
        sbx <= 1'b1;
        @(posedge mclk_in);
        sbx <= 1'b0;
        repeat (2) @(posedge mclk_in);
    endtask : wake

    initial begin
        repeat (16) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        rdk("csc_reset", 8'h00, 32'h0, 2'h0);
        rdk("unmapped", 8'h40, 32'h0, 2'h3);
        axw(8'h40, 32'h0, 2'h3);
        chk("osc_en_reset", 32'h1, {31'h0, oen});
        for (int c = 0; c < 4; c++) begin
            axw(8'h04, (32'(c) << 8) | 32'h3, 2'h0);
            repeat (10) @(posedge mclk_in);
            per(2, 32'h2 << c, "core_period");
            per(1, 32'h2 << c, "periph_period");
            per(0, 32'h10, "bus_period");
        end
        csw(32'h7, 32'h7);
        rdk("csc_mask", 8'h00, 32'h7, 2'h0);
        waitsub(1'b1);
        chk("on_sub", 32'h1, {31'h0, onsub});
        chk("osc_stop", 32'h0, {31'h0, oen});
        per(2, 32'h14, "sub_core");
        per(0, 32'h14, "sub_bus");
        @(posedge mclk_in) sby <= 1'b1;
        wake();
        rdk("wake_keep", 8'h00, 32'h7, 2'h0);
        chk("still_sub", 32'h1, {31'h0, onsub});
        csw(32'h1, 32'h1);
        repeat (4) @(negedge mclk_in);
        chk("osc_run", 32'h1, {31'h0, oen});
        @(posedge mclk_in) sby <= 1'b1;
        repeat (2) @(negedge mclk_in);
        chk("osc_sby", 32'h0, {31'h0, oen});
        wake();
        rdk("wake_clear", 8'h00, 32'h0, 2'h0);
        waitsub(1'b0);
        chk("back_main", 32'h0, {31'h0, onsub});
        per(2, 32'h10, "main_core");
        rdk("stat_main", 8'h08, 32'h4, 2'h0);
        @(posedge mclk_in) halt <= 1'b1;
        csw(32'h5, 32'h4);
        rdk("halt_block", 8'h00, 32'h4, 2'h0);
        close_out();
    end
endmodule : csel_clock_source_select_tb
`default_nettype wire

/* testbench/csel_sva.sv */
// Port checker for the clock source select block.
// Assumes bind to csel_clock_source_select; mclk_in is the only clock.
`timescale 1ns/1ps
`default_nettype none
module csel_sva (
    input wire logic        mclk_in,
    input wire logic        srst_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic        standby_in,
    input wire logic        standby_exit_in,
    input wire logic        core_clk_out,
    input wire logic        periph_clk_out,
    input wire logic        bus_clk_out,
    input wire logic        main_osc_en_out,
    input wire logic        pll_en_out,
    input wire logic        on_subclock_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    chk_osc_standby: assert property (standby_in |-> !main_osc_en_out)
        else $error("oscillator enabled in standby");
    chk_pll_with_osc: assert property (pll_en_out == main_osc_en_out)
        else $error("pll and oscillator enables differ");
    chk_sub_lockstep: assert property (on_subclock_out |->
        core_clk_out == periph_clk_out && periph_clk_out == bus_clk_out)
        else $error("clocks not together on subclock");
    chk_reset_quiet: assert property (disable iff (1'b0) srst_in |=>
        !on_subclock_out && !core_clk_out)
        else $error("reset did not restore main clock");
    chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    chk_w_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |-> ##[1:3] s_axi_bvalid_out)
        else $error("write response late");
    chk_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##2 s_axi_rvalid_out)
        else $error("read data late");
    cover property ($rose(on_subclock_out));
    cover property (standby_exit_in);
    cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h3);
endmodule : csel_sva
bind csel_clock_source_select csel_sva csel_sva_inst (.*);
`default_nettype wire
